// *** inc/facu_map.svh ***
`ifndef FACU_MAP_SVH
`define FACU_MAP_SVH

// Opcodes of the instructions handled here.
`define FACU_OP_ADD_REG 8'h21
`define FACU_OP_ADD_IMM 8'h33
`define FACU_OP_ADD_BASE 8'h2a
`define FACU_OP_CALL 8'h7e
`define FACU_OP_CMP_REG 8'h28
`define FACU_OP_CMP_IMM 8'h3a
`define FACU_OP_CMP_BASE 8'h31
`define FACU_OP_CMP_TWO 8'h3d
`define FACU_OP_SELECT_A 8'h01
`define FACU_OP_ARG_SETUP 8'hf0
`define FACU_OP_RETURN 8'h80
`define FACU_OP_STATUS_READ 8'hf1

// Compare status byte fields and reset value.
`define FACU_ST_NAN_BIT 2
`define FACU_ST_LT_BIT 1
`define FACU_ST_EQ_BIT 0
`define FACU_STATUS_RST 8'h00

// Base registers for the register-0 forms.
`define FACU_BASE_REG32 8'h00
`define FACU_BASE_REG64 8'h80

// Quiet NaN patterns.
`define FACU_NAN32 32'h7fc00000
`define FACU_NAN64 64'h7ff8000000000000

// Call nesting depth and number of stored functions.
`define FACU_CALL_DEPTH 16
`define FACU_FUNC_COUNT 64

`endif

// *** inc/facu_pkg.sv ***
package facu_pkg;

   typedef enum logic [2:0] {
      FACU_S_FETCH,
      FACU_S_HWAIT,
      FACU_S_PWAIT,
      FACU_S_PTAKE,
      FACU_S_RDB,
      FACU_S_RDA,
      FACU_S_EXE
   } facu_state_t;

endpackage : facu_pkg

// *** logic/facu_regfile.sv ***
// General register array: one write port, one read port, read data registered.
module facu_regfile #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata_r
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= mem[raddr];
      end
   end

endmodule : facu_regfile

// *** logic/facu_top.sv ***
// How it works
// - Register add sums named register into A.
// - Operand converted to A's width first.
// - Any NaN input gives NaN sum.
// - Plus infinity plus minus infinity gives NaN.
// - Single infinity addend passes through as sum.
// - Immediate add converts signed byte, adds.
// - Immediate add keeps NaN and infinities.
// - Base add uses register 0 or 128.
// - Call runs stored function 0 to 63.
// - Calls nest sixteen levels deep.
// - Call saves argument-setup or current selection.
// - Return restores saved A selection.
// - Undefined function called inside a function writes NaN to register 0.
// - Register compare sets status from difference.
// - Status bits: NaN, less, equal.
// - Status read returns the status byte.
// - Immediate compare against converted signed byte.
// - Base compare uses register 0 or 128.
// - Two-register compare: first minus second.
// - Second converted to first's width.
`include "facu_map.svh"

module facu_top (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic HOST_VALID,
   input wire logic [7:0] HOST_DATA,
   output logic HOST_READY,
   output logic PROG_RD,
   output logic [13:0] PROG_ADDR,
   input wire logic [7:0] PROG_DATA,
   input wire logic [63:0] FUNC_DEFINED,
   input wire logic FUNC_START,
   input wire logic [5:0] FUNC_NUM,
   input wire logic REG_WE,
   input wire logic [7:0] REG_WADDR,
   input wire logic [63:0] REG_WDATA,
   output logic [7:0] STATUS_BYTE,
   output logic STATUS_STB,
   output logic RESULT_VALID,
   output logic [7:0] RESULT_REG,
   output logic [63:0] RESULT_DATA,
   output logic [7:0] A_SEL,
   output logic [4:0] CALL_DEPTH
);

   // Doubles are used internally; denormals are flushed to zero and results truncate.
   function automatic logic [63:0] f_widen(input logic [31:0] s);
      logic [7:0] e;
      e = s[30:23];
      if (e == 8'h00)
         return {s[31], 63'h0};
      if (e == 8'hff)
         return {s[31], 11'h7ff, s[22:0], 29'h0};
      return {s[31], {3'h0, e} + 11'h380, s[22:0], 29'h0};
   endfunction : f_widen
   function automatic logic [31:0] f_narrow(input logic [63:0] d);
      logic [10:0] e;
      e = d[62:52];
      if (e == 11'h7ff)
         return {d[63], 8'hff, (|d[51:0]) ? (d[51:29] | 23'h400000) : 23'h0};
      if (e <= 11'h380)
         return {d[63], 31'h0};
      if (e >= 11'h47f)
         return {d[63], 8'hff, 23'h0};
      return {d[63], 8'(e - 11'h380), d[51:29]};
   endfunction : f_narrow
   function automatic logic [63:0] f_imm(input logic [7:0] v);
      logic [7:0] m;
      logic [63:0] sh;
      int p;
      m = v[7] ? 8'(-v) : v;
      p = 0;
      for (int i = 0; i < 8; i++)
         if (m[i])
            p = i;
      sh = {56'h0, m} << (52 - p);
      if (m == 8'h00)
         return 64'h0;
      return {v[7], 11'(1023 + p), sh[51:0]};
   endfunction : f_imm
   function automatic logic [63:0] f_add(input logic [63:0] x, input logic [63:0] y);
      logic xn, yn, xi, yi, swap;
      logic [63:0] big, sml;
      logic [55:0] mb, ms;
      logic [56:0] sum;
      logic [10:0] sh;
      logic signed [13:0] er;
      int p;
      xn = (&x[62:52]) && (|x[51:0]);
      yn = (&y[62:52]) && (|y[51:0]);
      xi = (&x[62:52]) && !(|x[51:0]);
      yi = (&y[62:52]) && !(|y[51:0]);
      if (xn || yn)
         return `FACU_NAN64;
      if (xi && yi && (x[63] != y[63]))
         return `FACU_NAN64;
      if (xi)
         return x;
      if (yi)
         return y;
      swap = y[62:0] > x[62:0];
      big = swap ? y : x;
      sml = swap ? x : y;
      mb = (big[62:52] == 11'h0) ? 56'h0 : {1'b1, big[51:0], 3'h0};
      ms = (sml[62:52] == 11'h0) ? 56'h0 : {1'b1, sml[51:0], 3'h0};
      sh = big[62:52] - sml[62:52];
      ms = (sh > 11'd55) ? 56'h0 : (ms >> sh);
      sum = (big[63] == sml[63]) ? ({1'b0, mb} + {1'b0, ms}) : ({1'b0, mb} - {1'b0, ms});
      if (sum == 57'h0)
         return 64'h0;
      p = 0;
      for (int i = 0; i < 57; i++)
         if (sum[i])
            p = i;
      er = $signed({3'h0, big[62:52]}) + 14'(p) - 14'sd55;
      if (er >= 14'sd2047)
         return {big[63], 11'h7ff, 52'h0};
      if (er <= 14'sd0)
         return {big[63], 63'h0};
      sum = (p >= 55) ? (sum >> (p - 55)) : (sum << (55 - p));
      return {big[63], er[10:0], sum[54:3]};
   endfunction : f_add
   // Ordering is taken from the operands directly; it matches the sign of the difference.
   function automatic logic [2:0] f_cmp(input logic [63:0] x, input logic [63:0] y);
      logic lt, eq;
      if (((&x[62:52]) && (|x[51:0])) || ((&y[62:52]) && (|y[51:0])))
         return 3'b100;
      eq = (x == y) || ((x[62:52] == 11'h0) && (y[62:52] == 11'h0));
      if (x[63] != y[63])
         lt = x[63];
      else if (!x[63])
         lt = x[62:0] < y[62:0];
      else
         lt = x[62:0] > y[62:0];
      return {1'b0, lt && !eq, eq};
   endfunction : f_cmp

   facu_pkg::facu_state_t state_r, state_nxt;
   logic [7:0] opc_r, op1_r, op2_r;
   logic [1:0] cnt_r;
   logic [7:0] a_sel_r, args_sel_r;
   logic args_active_r;
   logic in_func_r;
   logic [5:0] fn_r;
   logic [7:0] pc_r;
   logic [4:0] depth_r;
   logic [7:0] stk_sel [`FACU_CALL_DEPTH];
   logic [5:0] stk_fn [`FACU_CALL_DEPTH];
   logic [7:0] stk_pc [`FACU_CALL_DEPTH];
   logic stk_inf [`FACU_CALL_DEPTH];
   logic [63:0] b_r;
   logic [7:0] status_r;
   logic [63:0] rdata;

   // Byte arrival and instruction length decode.
   wire host_take = (state_r == facu_pkg::FACU_S_HWAIT) && HOST_VALID && !FUNC_START;
   wire byte_ok = host_take || (state_r == facu_pkg::FACU_S_PTAKE);
   wire [7:0] byte_in = (state_r == facu_pkg::FACU_S_PTAKE) ? PROG_DATA : HOST_DATA;
   wire [7:0] opc_cur = (cnt_r == 2'd0) ? byte_in : opc_r;
   wire two_ops = (opc_cur == `FACU_OP_CMP_TWO);
   wire one_op = (opc_cur == `FACU_OP_ADD_REG) || (opc_cur == `FACU_OP_ADD_IMM) ||
                 (opc_cur == `FACU_OP_CALL) || (opc_cur == `FACU_OP_CMP_REG) ||
                 (opc_cur == `FACU_OP_CMP_IMM) || (opc_cur == `FACU_OP_SELECT_A);
   wire [1:0] len = two_ops ? 2'd2 : (one_op ? 2'd1 : 2'd0);
   wire [1:0] cnt_left = (cnt_r == 2'd0) ? len : cnt_r - 2'd1;
   wire instr_done = byte_ok && (cnt_left == 2'd0);

   // Operand selection.
   wire is_add_reg = (opc_r == `FACU_OP_ADD_REG);
   wire is_add_imm = (opc_r == `FACU_OP_ADD_IMM);
   wire is_add_base = (opc_r == `FACU_OP_ADD_BASE);
   wire is_cmp_reg = (opc_r == `FACU_OP_CMP_REG);
   wire is_cmp_imm = (opc_r == `FACU_OP_CMP_IMM);
   wire is_cmp_base = (opc_r == `FACU_OP_CMP_BASE);
   wire is_cmp_two = (opc_r == `FACU_OP_CMP_TWO);
   wire is_add = is_add_reg || is_add_imm || is_add_base;
   wire is_cmp = is_cmp_reg || is_cmp_imm || is_cmp_base || is_cmp_two;
   wire is_imm = is_add_imm || is_cmp_imm;
   wire [7:0] aidx = is_cmp_two ? op1_r : a_sel_r;
   wire [7:0] base_idx = a_sel_r[7] ? `FACU_BASE_REG64 : `FACU_BASE_REG32;
   wire [7:0] bidx = is_cmp_two ? op2_r : ((is_add_reg || is_cmp_reg) ? op1_r : base_idx);
   wire a64 = aidx[7];

   // Datapath in double form; the operand is brought to A's width first.
   wire [63:0] a_d = a64 ? rdata : f_widen(rdata[31:0]);
   wire [63:0] b_raw = is_imm ? f_imm(op1_r) : (bidx[7] ? b_r : f_widen(b_r[31:0]));
   wire [63:0] b_d = a64 ? b_raw : f_widen(f_narrow(b_raw));
   wire [63:0] sum_d = f_add(a_d, b_d);
   wire [63:0] sum_w = a64 ? sum_d : {32'h0, f_narrow(sum_d)};
   wire [2:0] cmp_flags = f_cmp(a_d, b_d);

   // Call and return control.
   wire exe = (state_r == facu_pkg::FACU_S_EXE);
   wire is_call = (opc_r == `FACU_OP_CALL);
   wire is_ret = (opc_r == `FACU_OP_RETURN);
   wire stack_full = (depth_r == 5'(`FACU_CALL_DEPTH));
   wire call_undef = exe && is_call && in_func_r && !FUNC_DEFINED[op1_r[5:0]];
   wire call_go = exe && is_call && in_func_r && FUNC_DEFINED[op1_r[5:0]] && !stack_full;
   wire start_go = (state_r == facu_pkg::FACU_S_HWAIT) && FUNC_START && !stack_full;
   wire push = call_go || start_go;
   wire pop = exe && is_ret && (depth_r != 5'd0);
   wire [4:0] top = depth_r - 5'd1;
   wire [7:0] save_sel = args_active_r ? args_sel_r : a_sel_r;
   wire [5:0] new_fn = start_go ? FUNC_NUM : op1_r[5:0];

   // Register array port use: execution writes win, host loads only while idle.
   wire fsm_we = exe && (is_add || call_undef);
   wire host_we = (state_r == facu_pkg::FACU_S_HWAIT) && REG_WE;
   wire rf_we = fsm_we || host_we;
   wire [7:0] rf_waddr = fsm_we ? (call_undef ? `FACU_BASE_REG32 : aidx) : REG_WADDR;
   wire [63:0] wr_data = call_undef ? {32'h0, `FACU_NAN32} : sum_w;
   wire [63:0] rf_wdata = fsm_we ? wr_data : REG_WDATA;
   wire [7:0] rf_raddr = (state_r == facu_pkg::FACU_S_RDB) ? bidx : aidx;

   facu_regfile #(.WIDTH(64), .DEPTH(256), .AW(8)) u_regs (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .we(rf_we),
      .waddr(rf_waddr),
      .wdata(rf_wdata),
      .raddr(rf_raddr),
      .rdata_r(rdata)
   );
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         facu_pkg::FACU_S_FETCH:
            state_nxt = in_func_r ? facu_pkg::FACU_S_PWAIT : facu_pkg::FACU_S_HWAIT;
         facu_pkg::FACU_S_HWAIT:
            if (start_go)
               state_nxt = facu_pkg::FACU_S_FETCH;
            else if (instr_done)
               state_nxt = facu_pkg::FACU_S_RDB;
         facu_pkg::FACU_S_PWAIT:
            state_nxt = facu_pkg::FACU_S_PTAKE;
         facu_pkg::FACU_S_PTAKE:
            state_nxt = instr_done ? facu_pkg::FACU_S_RDB : facu_pkg::FACU_S_FETCH;
         facu_pkg::FACU_S_RDB:
            state_nxt = facu_pkg::FACU_S_RDA;
         facu_pkg::FACU_S_RDA:
            state_nxt = facu_pkg::FACU_S_EXE;
         default:
            state_nxt = facu_pkg::FACU_S_FETCH;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         state_r <= facu_pkg::FACU_S_FETCH;
         opc_r <= 8'h00;
         op1_r <= 8'h00;
         op2_r <= 8'h00;
         cnt_r <= 2'd0;
         b_r <= 64'h0;
      end
      else
      begin
         state_r <= state_nxt;
         if (byte_ok)
         begin
            cnt_r <= cnt_left;
            if (cnt_r == 2'd0)
               opc_r <= byte_in;
            else if (two_ops && (cnt_r == 2'd1))
               op2_r <= byte_in;
            else
               op1_r <= byte_in;
         end
         if (state_r == facu_pkg::FACU_S_RDA)
            b_r <= rdata;
      end
   end

   // Selection of A, argument setup and the call stack.
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         a_sel_r <= 8'h00;
         args_sel_r <= 8'h00;
         args_active_r <= 1'b0;
         in_func_r <= 1'b0;
         fn_r <= 6'h00;
         pc_r <= 8'h00;
         depth_r <= 5'd0;
      end
      else if (push)
      begin
         stk_sel[depth_r[3:0]] <= save_sel;
         stk_fn[depth_r[3:0]] <= fn_r;
         stk_pc[depth_r[3:0]] <= pc_r;
         stk_inf[depth_r[3:0]] <= in_func_r;
         args_active_r <= 1'b0;
         depth_r <= depth_r + 5'd1;
         in_func_r <= 1'b1;
         fn_r <= new_fn;
         pc_r <= 8'h00;
      end
      else if (pop)
      begin
         a_sel_r <= stk_sel[top[3:0]];
         fn_r <= stk_fn[top[3:0]];
         pc_r <= stk_pc[top[3:0]];
         in_func_r <= stk_inf[top[3:0]];
         depth_r <= top;
      end
      else
      begin
         if (state_r == facu_pkg::FACU_S_PTAKE)
            pc_r <= pc_r + 8'h01;
         if (exe && (opc_r == `FACU_OP_SELECT_A))
            a_sel_r <= op1_r;
         // Only the first setup since the last call is remembered.
         if (exe && (opc_r == `FACU_OP_ARG_SETUP) && !args_active_r)
         begin
            args_active_r <= 1'b1;
            args_sel_r <= a_sel_r;
         end
      end
   end

   // Status byte, result reporting and the port strobes; HOST_READY and PROG_RD follow the next state so they
   // stand in the same cycle as the state they announce.
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         status_r <= `FACU_STATUS_RST;
         STATUS_STB <= 1'b0;
         RESULT_VALID <= 1'b0;
         RESULT_REG <= 8'h00;
         RESULT_DATA <= 64'h0;
         PROG_ADDR <= 14'h0;
         HOST_READY <= 1'b0;
         PROG_RD <= 1'b0;
      end
      else
      begin
         if (exe && is_cmp)
            status_r <= {5'h00, cmp_flags};
         STATUS_STB <= exe && (opc_r == `FACU_OP_STATUS_READ);
         RESULT_VALID <= fsm_we;
         if (fsm_we)
         begin
            RESULT_REG <= rf_waddr;
            RESULT_DATA <= wr_data;
         end
         if (state_nxt == facu_pkg::FACU_S_PWAIT)
            PROG_ADDR <= {fn_r, pc_r};
         HOST_READY <= (state_nxt == facu_pkg::FACU_S_HWAIT);
         PROG_RD <= (state_nxt == facu_pkg::FACU_S_PWAIT);
      end
   end

   assign STATUS_BYTE = status_r;
   assign A_SEL = a_sel_r;
   assign CALL_DEPTH = depth_r;

endmodule : facu_top

// *** test/facu_prog_model.sv ***
module facu_prog_model (
   input wire logic clk,
   input wire logic rd,
   input wire logic [13:0] addr,
   output logic [7:0] data,
   output logic [63:0] defined
);
   timeunit 1ns;
   timeprecision 100ps;
   // Function 1 nests a call, records a selection and calls the missing function 3.
   localparam logic [79:0] FN1 = 80'h01_09_f0_01_0a_7e_02_7e_03_80;
   // Function 4 calls itself until the nesting limit refuses the call.
   localparam logic [23:0] FN4 = 24'h7e_04_80;
   localparam logic [23:0] FN2 = 24'h01_07_80;
   logic [7:0] byte_at;
   assign defined = 64'h0000000000000016;
   initial data = 8'h5a;
   // Calls stand only inside stored functions, never in the host stream.
   always_comb
   begin
      byte_at = ~data;
      if (addr[13:8] == 6'h01 && addr[7:0] < 8'h0a)
         byte_at = 8'(FN1 >> (8 * (9 - addr[7:0])));
      if (addr[13:8] == 6'h02 && addr[7:0] < 8'h03)
         byte_at = 8'(FN2 >> (8 * (2 - addr[7:0])));
      if (addr[13:8] == 6'h04 && addr[7:0] < 8'h03)
         byte_at = 8'(FN4 >> (8 * (2 - addr[7:0])));
   end
   // Outside a read the data lines keep changing so a late sample cannot look valid.
   always @(posedge clk)
      data <= rd ? byte_at : ~data;
endmodule : facu_prog_model

// *** test/facu_top_props.sv ***
module facu_top_props (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic HOST_READY,
   input wire logic PROG_RD,
   input wire logic [13:0] PROG_ADDR,
   input wire logic [7:0] STATUS_BYTE,
   input wire logic STATUS_STB,
   input wire logic RESULT_VALID,
   input wire logic [7:0] RESULT_REG,
   input wire logic [63:0] RESULT_DATA,
   input wire logic [4:0] CALL_DEPTH
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);
   AST_STB_UPPER: assert property (STATUS_STB |-> STATUS_BYTE[7:3] == 5'h00)
      else $error("status upper bits set");
   AST_NAN_ALONE: assert property (STATUS_BYTE[2] |-> STATUS_BYTE[1:0] == 2'h0)
      else $error("nan flag with order flags");
   AST_STATUS_QUIET: assert property (!$stable(STATUS_BYTE) |-> !RESULT_VALID && !HOST_READY)
      else $error("status changed outside a compare");
   AST_STB_READY: assert property (STATUS_STB && CALL_DEPTH == 5'h00 |=> HOST_READY)
      else $error("host not ready after status read");
   AST_DEPTH_MAX: assert property (CALL_DEPTH <= 5'h10)
      else $error("call depth beyond limit");
   AST_DEPTH_STEP: assert property (CALL_DEPTH != $past(CALL_DEPTH) |->
      CALL_DEPTH == $past(CALL_DEPTH) + 5'h01 || CALL_DEPTH + 5'h01 == $past(CALL_DEPTH))
      else $error("call depth jumped");
   AST_PROG_GAP: assert property (PROG_RD |=> !PROG_RD [*2])
      else $error("program reads too close");
   AST_PROG_HOLD: assert property (PROG_RD |=> $stable(PROG_ADDR))
      else $error("program address moved");
   AST_PROG_IN_FN: assert property (PROG_RD |-> CALL_DEPTH != 5'h00)
      else $error("program read outside a function");
   AST_RES_BUSY: assert property (RESULT_VALID |-> !HOST_READY)
      else $error("result while waiting for host");
   AST_NARROW: assert property (RESULT_VALID && !RESULT_REG[7] |-> RESULT_DATA[63:32] == 32'h0)
      else $error("wide data in narrow register");
endmodule : facu_top_props

bind facu_top facu_top_props u_props (.CLK_SYS, .SYS_RST, .HOST_READY, .PROG_RD, .PROG_ADDR, .STATUS_BYTE,
   .STATUS_STB, .RESULT_VALID, .RESULT_REG, .RESULT_DATA, .CALL_DEPTH);

// *** test/test_float_add_compare_call_unit.sv ***
module test_float_add_compare_call_unit;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK_SYS = 1'b0;
   logic SYS_RST = 1'b1;
   logic HOST_VALID = 1'b0;
   logic [7:0] HOST_DATA = 8'h00;
   logic FUNC_START = 1'b0;
   logic [5:0] FUNC_NUM = 6'h00;
   logic REG_WE = 1'b0;
   logic [7:0] REG_WADDR = 8'h00;
   logic [63:0] REG_WDATA = 64'h0;
   logic HOST_READY, PROG_RD, STATUS_STB, RESULT_VALID;
   logic [13:0] PROG_ADDR;
   logic [7:0] PROG_DATA, STATUS_BYTE, RESULT_REG, A_SEL, res_reg, res_sel, stb_byte;
   logic [63:0] FUNC_DEFINED, RESULT_DATA, res_data;
   logic [4:0] CALL_DEPTH, max_depth;
   int failures = 0;
   int tests_run = 0;
   facu_top u_dut (.CLK_SYS, .SYS_RST, .HOST_VALID, .HOST_DATA, .HOST_READY, .PROG_RD, .PROG_ADDR, .PROG_DATA,
      .FUNC_DEFINED, .FUNC_START, .FUNC_NUM, .REG_WE, .REG_WADDR, .REG_WDATA, .STATUS_BYTE, .STATUS_STB,
      .RESULT_VALID, .RESULT_REG, .RESULT_DATA, .A_SEL, .CALL_DEPTH);
   facu_prog_model u_prog (.clk(CLK_SYS), .rd(PROG_RD), .addr(PROG_ADDR), .data(PROG_DATA),
      .defined(FUNC_DEFINED));
   always #5 CLK_SYS = ~CLK_SYS;
   // One-cycle pulses are caught here so the tasks may look after the instruction ends.
   always @(posedge CLK_SYS)
   begin
      if (RESULT_VALID === 1'b1)
      begin
         res_reg <= RESULT_REG;
         res_data <= RESULT_DATA;
         res_sel <= A_SEL;
      end
      if (STATUS_STB === 1'b1)
         stb_byte <= STATUS_BYTE;
      if (FUNC_START)
         max_depth <= 5'h00;
      else if (CALL_DEPTH > max_depth)
         max_depth <= CALL_DEPTH;
   end
   task automatic test_done(input logic hung);
      if (hung)
         failures++;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick;
      @(posedge CLK_SYS);
      #1;
   endtask : tick
   task automatic wait_ready(input int lim);
      int n;
      n = 0;
      while (HOST_READY !== 1'b1 && n < lim)
      begin
         tick();
         n++;
      end
      if (HOST_READY !== 1'b1)
         test_done(1'b1);
   endtask : wait_ready
   task automatic hb(input logic [7:0] b);
      wait_ready(50);
      HOST_DATA = b;
      HOST_VALID = 1'b1;
      tick();
   endtask : hb
   // The strobe stays high across the bytes of one instruction and drops for a full cycle after its last byte.
   task automatic ins(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
      hb(b0);
      if (n > 1)
         hb(b1);
      if (n > 2)
         hb(b2);
      HOST_VALID = 1'b0;
      tick();
      wait_ready(50);
   endtask : ins
   task automatic wr(input logic [7:0] a, input logic [63:0] d);
      wait_ready(50);
      REG_WE = 1'b1;
      REG_WADDR = a;
      REG_WDATA = d;
      tick();
      REG_WE = 1'b0;
      tick();
   endtask : wr
   task automatic test_cmp;
      logic [31:0] t [8];
      // Each entry is opcode, first operand, second operand, expected status.
      t = '{32'h28060002, 32'h28810002, 32'h3a010001, 32'h3a800000, 32'h31000004, 32'h3d060500,
         32'h3d050602, 32'h3d800501};
      ins(8'h01, 8'h05, 8'h00, 2);
      wr(8'h05, 64'h3f800000);
      wr(8'h06, 64'h40000000);
      wr(8'h00, 64'h7fc00000);
      wr(8'h80, 64'h3ff0000000000000);
      wr(8'h81, 64'h4000000000000000);
      for (int i = 0; i < 8; i++)
      begin
         ins(t[i][31:24], t[i][23:16], t[i][15:8], t[i][31:24] == 8'h31 ? 1 : t[i][31:24] == 8'h3d ? 3 : 2);
         ins(8'hf1, 8'h00, 8'h00, 1);
         check("status", stb_byte, t[i][7:0]);
      end
      $display("test compare done");
   endtask : test_cmp
   task automatic test_add;
      logic [143:0] t [7];
      t = '{{64'h3ff8000000000000, 16'h2181, 64'h400c000000000000},
         {64'h3ff8000000000000, 16'h2105, 64'h4004000000000000},
         {64'h7ff0000000000000, 16'h2182, 64'h7ff8000000000000},
         {64'h7ff0000000000000, 16'h2181, 64'h7ff0000000000000},
         {64'h7ff8000000000000, 16'h2181, 64'h7ff8000000000000},
         {64'h3ff8000000000000, 16'h33fe, 64'hbfe0000000000000},
         {64'hfff0000000000000, 16'h3305, 64'hfff0000000000000}};
      ins(8'h01, 8'h80, 8'h00, 2);
      wr(8'h82, 64'hfff0000000000000);
      for (int i = 0; i < 7; i++)
      begin
         wr(8'h80, t[i][143:80]);
         ins(t[i][79:72], t[i][71:64], 8'h00, 2);
         check("add", {res_reg, res_data}, {8'h80, t[i][63:0]});
      end
      check("status kept", STATUS_BYTE, 8'h01);
      wr(8'h80, 64'h3ff8000000000000);
      ins(8'h2a, 8'h00, 8'h00, 1);
      check("base add wide", {res_reg, res_data}, {8'h80, 64'h4008000000000000});
      ins(8'h01, 8'h05, 8'h00, 2);
      wr(8'h00, 64'h40000000);
      ins(8'h2a, 8'h00, 8'h00, 1);
      check("base add narrow", {res_reg, res_data}, {8'h05, 64'h40400000});
      $display("test add done");
   endtask : test_add
   task automatic call_fn(input logic [5:0] f);
      wait_ready(50);
      FUNC_NUM = f;
      FUNC_START = 1'b1;
      tick();
      FUNC_START = 1'b0;
      tick();
      wait_ready(3000);
   endtask : call_fn
   task automatic test_call;
      call_fn(6'h01);
      check("undefined call", {res_reg, res_data}, {8'h00, 64'h7fc00000});
      check("saved selection", res_sel, 8'h09);
      check("host selection", A_SEL, 8'h05);
      check("depth", max_depth, 5'h02);
      call_fn(6'h04);
      check("deepest", max_depth, 5'h10);
      check("unwound", CALL_DEPTH, 5'h00);
      $display("test call done");
   endtask : test_call
   initial
   begin
      repeat (10) @(posedge CLK_SYS);
      #1;
      SYS_RST = 1'b0;
      test_cmp();
      test_add();
      test_call();
      test_done(1'b0);
   end
endmodule : test_float_add_compare_call_unit
